/* sector_guard_and_rf_activity_pin_test.sv */
// Purpose: Self-checking bench for the sector guard block
// Assumes: Inputs move on the falling edge of i_mclk
// Notes: Host results are queued and matched by a watcher
`timescale 1ns/1ps
`default_nettype none
module sector_guard_and_rf_activity_pin_test;
  import ssg_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic rclk, sof, bad, done, wend, ans, pwd, pok, fld, rd_ok, wr_ok, hbusy, hpwd, tprog, sel, wr, rd;
  logic ack, err, pin_o, pin_oe, pwr, sink, eh_en;
  logic [1:0] idx, eh_lvl;
  logic [5:0] sector;
  logic [12:0] addr;
  logic [7:0] wdata, rdata;
  logic [7:0] lk [8];
  logic [7:0] st [8] = '{8'h01, 8'h09, 8'h0b, 8'h0d, 8'h0f, 8'h00, 8'h15, 8'h1d};
  logic [9:0] expq [$];
  logic [9:0] e;
  int mismatches = 0;
  int compares = 0;
  int cyc = 0;
  logic rgo = 1'b0;
  logic [8:0] rev = 9'h000;
  always #5 i_mclk = ~i_mclk;
  ssg_rf_reader ssg_rf_reader_inst (.i_go(rgo), .i_ev(rev), .o_clk(rclk), .o_sof(sof), .o_bad(bad),
    .o_done(done), .o_wend(wend),
    .o_ans(ans), .o_pwd(pwd), .o_ok(pok), .o_idx(idx));
  ssg_sector_guard ssg_sector_guard_inst (.i_mclk(i_mclk), .i_rst(i_rst), .i_rf_clk(rclk), .i_rf_sof(sof),
    .i_rf_crc_bad(bad), .i_rf_cmd_done(done), .i_rf_write_end(wend), .i_rf_answer_start(ans),
    .i_rf_pwd_present(pwd), .i_rf_pwd_ok(pok), .i_rf_pwd_idx(idx), .i_rf_field_on(fld), .i_rf_sector(sector),
    .o_rf_rd_ok(rd_ok), .o_rf_wr_ok(wr_ok), .i_host_busy(hbusy), .i_host_pwd_ok(hpwd), .i_host_tprog(tprog),
    .i_system_area_select(sel), .i_host_addr(addr), .i_host_wdata(wdata), .i_host_wr(wr), .i_host_rd(rd),
    .o_host_rdata(rdata), .o_host_ack(ack), .o_host_err(err), .o_rf_activity_pin_o(pin_o),
    .o_rf_activity_pin_oe(pin_oe), .i_min_rf_input_power(pwr), .i_sink_ok(sink), .o_eh_out_en(eh_en),
    .o_eh_level(eh_lvl));
  task automatic stop_test();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Result watcher: oldest note against each answer
  always @(negedge i_mclk) begin
    if (ack === 1'b1 || err === 1'b1) begin
      if (expq.size() == 0) chk({7'h0, err}, 8'hff);
      else begin
        e = expq.pop_front();
        chk({7'h0, err}, {7'h0, e[8]});
        if (e[9] && !e[8]) chk(rdata, e[7:0]);
      end
    end
  end
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic host(input logic w, s, input logic [12:0] a, input logic [7:0] d, input logic p, x,
                      input logic [7:0] q);
    @(negedge i_mclk);
    wr = w;
    rd = !w;
    sel = s;
    addr = a;
    wdata = d;
    hpwd = p;
    expq.push_back({!w, x, q});
    @(negedge i_mclk);
    wr = 1'b0;
    rd = 1'b0;
  endtask
  task automatic rights(input logic [5:0] s, input logic [1:0] x);
    @(negedge i_mclk);
    sector = s;
    @(negedge i_mclk);
    chk({6'h0, rd_ok, wr_ok}, {6'h0, x});
  endtask
  task automatic pin(input logic x);
    @(negedge i_mclk);
    chk({6'h0, pin_o, pin_oe}, {7'h0, x});
  endtask
  // Event lines settle before go rises; go falls early so the reader rearms
  task automatic send(input logic [8:0] v);
    rev = v;
    #1 rgo = 1'b1;
    #119 rgo = 1'b0;
    #120;
  endtask
  // Expected rights: {read, write}, p is the accepted password, 0 for none
  function automatic logic [1:0] acc(input logic [7:0] s, input int p);
    if (!s[0]) return 2'b11;
    if (s[4:3] != 2'h0 && s[4:3] == 2'(p)) return (s[2:1] == 2'h3) ? 2'b10 : 2'b11;
    if (s[2:1] == 2'h0) return 2'b10;
    if (s[2:1] == 2'h1) return 2'b11;
    return 2'b00;
  endfunction
  initial begin
    {hbusy, hpwd, tprog, sel, wr, rd, fld, pwr, sink, sector, addr, wdata} = '0;
    void'($urandom(32'h776b));
    repeat (8) @(negedge i_mclk);
    i_rst = 1'b0;
    repeat (4) @(negedge i_mclk);
    for (int j = 0; j < 8; j++) host(0, 1, LOCK_LOW_ADDR + 13'(j), 0, 0, 0, 8'h00);
    host(0, 1, CONFIG_ADDR, 0, 0, 0, 8'h00);
    host(0, 1, CONTROL_ADDR, 0, 0, 0, 8'h01);
    host(0, 1, 13'h0a00, 0, 0, 1, 0);
    host(1, 1, LOCK_HIGH_ADDR, 8'hff, 0, 1, 0);
    host(0, 1, LOCK_HIGH_ADDR, 0, 0, 0, 8'h00);
    for (int j = 0; j < 8; j++) begin
      lk[j] = 8'($urandom);
      host(1, 1, LOCK_LOW_ADDR + 13'(j), lk[j], 1, 0, 0);
      host(0, 1, LOCK_LOW_ADDR + 13'(j), 0, 0, 0, lk[j]);
    end
    for (int s = 0; s < 64; s++) host(1, 0, 13'(s * 128 + 5), 8'h5a, 0, lk[s / 8][s % 8], 0);
    host(1, 1, SSB_BASE, 8'h1f, 0, 1, 0);
    for (int s = 0; s < 8; s++) begin
      host(1, 1, SSB_BASE + 13'(s), st[s] | 8'he0, 1, 0, 0);
      host(0, 1, SSB_BASE + 13'(s), 0, 0, 0, st[s]);
    end
    fld = 1'b1;
    for (int p = 1; p < 4; p++) begin
      send({2'(p), 2'b01, 5'h00});
      for (int s = 0; s < 8; s++) rights(6'(s), acc(st[s], 0));
      send({2'(p), 2'b11, 5'h00});
      for (int s = 0; s < 8; s++) rights(6'(s), acc(st[s], p));
    end
    send(9'h001);
    pin(1'b1);
    send(9'h004);
    pin(1'b0);
    send(9'h001);
    hbusy = 1'b1;
    pin(1'b0);
    hbusy = 1'b0;
    pin(1'b1);
    send(9'h002);
    pin(1'b0);
    send(9'h008);
    pin(1'b0);
    send(9'h001);
    fld = 1'b0;
    repeat (6) @(negedge i_mclk);
    pin(1'b0);
    fld = 1'b1;
    host(1, 1, CONFIG_ADDR, 8'h08, 0, 0, 0);
    send(9'h001);
    pin(1'b0);
    send(9'h008);
    pin(1'b1);
    hbusy = 1'b1;
    pin(1'b0);
    hbusy = 1'b0;
    pin(1'b1);
    send(9'h010);
    pin(1'b0);
    for (int c = 0; c < 16; c++) begin
      host(1, 1, CONFIG_ADDR, {6'h0, 2'(c)}, 0, 0, 0);
      host(1, 1, CONTROL_ADDR, {7'h7f, c[2]}, 0, 0, 0);
      pwr = c[3];
      sink = 1'($urandom);
      tprog = 1'($urandom);
      repeat (3) @(negedge i_mclk);
      chk({6'h0, eh_lvl}, {6'h0, 2'(c)});
      chk({7'h0, eh_en}, {7'h0, c[2] & c[3] & sink});
      host(0, 1, CONFIG_ADDR, 0, 0, 0, {6'h0, 2'(c)});
      host(0, 1, CONTROL_ADDR, 0, 0, 0, {tprog, 5'h00, 1'b1, c[2]});
    end
    // Second reset in mid-run: locks, config and harvest default come back
    i_rst = 1'b1;
    repeat (4) @(negedge i_mclk);
    i_rst = 1'b0;
    repeat (4) @(negedge i_mclk);
    pin(1'b0);
    host(0, 1, LOCK_LOW_ADDR, 0, 0, 0, 8'h00);
    host(0, 1, CONFIG_ADDR, 0, 0, 0, 8'h00);
    host(0, 1, CONTROL_ADDR, 0, 0, 0, {tprog, 5'h00, 1'b1, 1'b1});
    repeat (4) @(negedge i_mclk);
    if (expq.size() != 0) mismatches++;
    stop_test();
  end
endmodule // sector_guard_and_rf_activity_pin_test
`default_nettype wire

/* ssg_pkg.sv */
// Purpose: Constants and types shared by the sector guard block
// Assumes: Host byte addresses are 13 bits wide
// Notes: Values below are the device's own map
`default_nettype none
package ssg_pkg;
  localparam int unsigned ADDR_W = 13;
  localparam int unsigned SECTORS = 64;
  localparam int unsigned SEC_W = 6;
  // ----------------------------------------
  // System area map
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] SSB_BASE = 13'h0000;
  localparam logic [ADDR_W-1:0] LOCK_LOW_ADDR = 13'h0800;
  localparam logic [ADDR_W-1:0] LOCK_HIGH_ADDR = 13'h0804;
  localparam logic [ADDR_W-1:0] CONFIG_ADDR = 13'h0910;
  localparam logic [ADDR_W-1:0] CONTROL_ADDR = 13'h0920;
  localparam int unsigned LOCK_BYTES = 8;
  localparam int unsigned USER_SEC_LSB = 7;
  localparam logic [63:0] LOCK_RESET = 64'h0000_0000_0000_0000;
  // Stored byte is outside this block; value is a plain default
  localparam logic [7:0] CONFIG_DEFAULT = 8'h00;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int unsigned CFG_ACT_MODE = 3;
  localparam int unsigned CFG_EH_MODE = 2;
  localparam int unsigned CFG_EH_LVL_HI = 1;
  localparam int unsigned CTL_EH_EN = 0;
  localparam int unsigned CTL_FIELD = 1;
  localparam int unsigned CTL_TPROG = 7;
  localparam int unsigned SSB_LOCK = 0;
  localparam int unsigned SSB_RW_LO = 1;
  localparam int unsigned SSB_PW_LO = 3;
  localparam logic [4:0] SSB_WR_MASK = 5'h1f;
  // ----------------------------------------
  // Access field codes and password links
  // ----------------------------------------
  localparam logic [1:0] RW_00 = 2'h0;
  localparam logic [1:0] RW_01 = 2'h1;
  localparam logic [1:0] RW_10 = 2'h2;
  localparam logic [1:0] RW_11 = 2'h3;
  localparam logic [1:0] PW_NONE = 2'h0;
  localparam int unsigned NUM_PWD = 3;
  // Synchronised RF lines, in bit order
  localparam int unsigned RF_W = 10;
  localparam int unsigned RB_CLK = 0;
  localparam int unsigned RB_SOF = 1;
  localparam int unsigned RB_CRC_BAD = 2;
  localparam int unsigned RB_DONE = 3;
  localparam int unsigned RB_WR_END = 4;
  localparam int unsigned RB_ANS = 5;
  localparam int unsigned RB_PWD = 6;
  localparam int unsigned RB_PWD_OK = 7;
  localparam int unsigned RB_IDX = 8;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_BUSY = 3'h2,
    ST_WIP = 3'h4
  } ssg_pin_st_t;
endpackage
`default_nettype wire

/* ssg_rf_reader.sv */
// Purpose: RF reader stand-in for the sector guard bench
// Assumes: Event lines change only while the link clock is low
// Notes: Link clock stands still low between frames; a rise on i_go starts one event
`timescale 1ns/1ps
`default_nettype none
module ssg_rf_reader (
  input wire logic i_go,
  input wire logic [8:0] i_ev,
  output logic o_clk,
  output logic o_sof,
  output logic o_bad,
  output logic o_done,
  output logic o_wend,
  output logic o_ans,
  output logic o_pwd,
  output logic o_ok,
  output logic [1:0] o_idx
);
  initial begin
    o_clk = 1'b0;
    {o_idx, o_ok, o_pwd, o_ans, o_wend, o_done, o_bad, o_sof} = 9'h000;
  end
  // One rising edge per event, lines held well past it for the sampler
  always @(posedge i_go) begin
    {o_idx, o_ok, o_pwd, o_ans, o_wend, o_done, o_bad, o_sof} = i_ev;
    #80 o_clk = 1'b1;
    #80 o_clk = 1'b0;
    #40 {o_idx, o_ok, o_pwd, o_ans, o_wend, o_done, o_bad, o_sof} = 9'h000;
  end
endmodule // ssg_rf_reader
`default_nettype wire

/* ssg_sector_guard.sv */
// Purpose: Sector rights, serial write locks, config and activity pin
// Assumes: RF lines change on the RF clock's falling edge
// Notes: RF events are taken at the sampled rising edge of i_rf_clk
`timescale 1ns/1ps
`default_nettype none
// Function
// - Correct password 1 grants its sectors' rights
// - Locked sector access follows protection field
// - Two status bits link sector to password
// - Wrong password revokes all granted rights
// - Serial write locks live in eight bytes
// - Lock bit one blocks serial writes
// - One lock bit per sector, two words
// - Lock area read free, write needs password
// - Lock bytes reset to zero
// - Configuration byte holds pin and harvest setup
// - Control register holds harvest enable, field
// - Activity pin pulls low or floats only
// - Config bit3 low selects busy mode
// - Busy: low from start of frame to done
// - Bad command: low only until CRC
// - Field loss releases the pin
// - Busy mode floats during serial commands
// - Config bit3 high selects write mode
// - Write mode: low from write end to answer
// - Write mode floats during serial writes
// - Harvest output needs enable, power, load
// - Four selectable harvest current levels
module ssg_sector_guard (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_rf_clk,
  input wire logic i_rf_sof,
  input wire logic i_rf_crc_bad,
  input wire logic i_rf_cmd_done,
  input wire logic i_rf_write_end,
  input wire logic i_rf_answer_start,
  input wire logic i_rf_pwd_present,
  input wire logic i_rf_pwd_ok,
  input wire logic [1:0] i_rf_pwd_idx,
  input wire logic i_rf_field_on,
  input wire logic [ssg_pkg::SEC_W-1:0] i_rf_sector,
  output logic o_rf_rd_ok,
  output logic o_rf_wr_ok,
  input wire logic i_host_busy,
  input wire logic i_host_pwd_ok,
  input wire logic i_host_tprog,
  input wire logic i_system_area_select,
  input wire logic [ssg_pkg::ADDR_W-1:0] i_host_addr,
  input wire logic [7:0] i_host_wdata,
  input wire logic i_host_wr,
  input wire logic i_host_rd,
  output logic [7:0] o_host_rdata,
  output logic o_host_ack,
  output logic o_host_err,
  output logic o_rf_activity_pin_o,
  output logic o_rf_activity_pin_oe,
  input wire logic i_min_rf_input_power,
  input wire logic i_sink_ok,
  output logic o_eh_out_en,
  output logic [1:0] o_eh_level
);
  import ssg_pkg::*;

  typedef struct packed {
    ssg_pin_st_t st;
    logic rfclk_q;
    logic [NUM_PWD-1:0] pwd_ok;
    logic [SECTORS-1:0][7:0] ssb;
    logic [SECTORS-1:0] lock;
    logic [7:0] cfg;
    logic eh_en;
    logic init;
    logic [7:0] rdata;
    logic ack;
    logic err;
    logic rd_ok;
    logic wr_ok;
  } ssg_core_t;

  ssg_core_t s_r;
  ssg_core_t s_nxt;
  logic [RF_W-1:0] rf_async;
  logic [RF_W-1:0] rf_s;
  logic rf_edge;
  logic field;
  logic wip_mode;
  logic [7:0] sel_ssb;
  logic granted;
  logic [2:0] lock_byte;
  logic [SEC_W-1:0] host_sec;

  // ----------------------------------------
  // RF side synchronisation
  // ----------------------------------------
  assign rf_async = {i_rf_pwd_idx, i_rf_pwd_ok, i_rf_pwd_present, i_rf_answer_start,
                     i_rf_write_end, i_rf_cmd_done, i_rf_crc_bad, i_rf_sof, i_rf_clk};

  ssg_sync3 #(
    .W(RF_W)
  ) u_rf_sync (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_async(rf_async),
    .o_q(rf_s)
  );

  ssg_sync3 #(
    .W(1)
  ) u_field_sync (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_async(i_rf_field_on),
    .o_q(field)
  );

  assign rf_edge = rf_s[RB_CLK] & ~s_r.rfclk_q;
  assign wip_mode = s_r.cfg[CFG_ACT_MODE];
  assign sel_ssb = s_r.ssb[i_rf_sector];
  assign granted = (sel_ssb[SSB_PW_LO+:2] != PW_NONE) &&
                   s_r.pwd_ok[sel_ssb[SSB_PW_LO+:2] - 2'h1];
  assign lock_byte = i_host_addr[2:0];
  assign host_sec = i_host_addr[USER_SEC_LSB+:SEC_W];

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.rfclk_q = rf_s[RB_CLK];
    s_nxt.ack = 1'b0;
    s_nxt.err = 1'b0;
    s_nxt.init = 1'b0;
    // Harvest default taken once after reset release, from stored mode
    if (s_r.init) begin
      s_nxt.eh_en = ~s_r.cfg[CFG_EH_MODE];
    end

    // Password state, sampled at RF clock edges
    if (rf_edge && rf_s[RB_PWD]) begin
      if (rf_s[RB_PWD_OK] && rf_s[RB_IDX+:2] != PW_NONE) begin
        s_nxt.pwd_ok[rf_s[RB_IDX+:2] - 2'h1] = 1'b1;
      end else begin
        s_nxt.pwd_ok = '0;
      end
    end

    // Access rights of the queried sector
    if (!sel_ssb[SSB_LOCK]) begin
      s_nxt.rd_ok = 1'b1;
      s_nxt.wr_ok = 1'b1;
    end else begin
      unique case (sel_ssb[SSB_RW_LO+:2])
        RW_00: begin
          s_nxt.rd_ok = 1'b1;
          s_nxt.wr_ok = granted;
        end
        RW_01: begin
          s_nxt.rd_ok = 1'b1;
          s_nxt.wr_ok = 1'b1;
        end
        RW_10: begin
          s_nxt.rd_ok = granted;
          s_nxt.wr_ok = granted;
        end
        RW_11: begin
          s_nxt.rd_ok = granted;
          s_nxt.wr_ok = 1'b0;
        end
      endcase
    end

    // Activity pin sequencer
    unique case (s_r.st)
      ST_IDLE: begin
        if (field && rf_edge) begin
          if (!wip_mode && rf_s[RB_SOF]) begin
            s_nxt.st = ST_BUSY;
          end else if (wip_mode && rf_s[RB_WR_END]) begin
            s_nxt.st = ST_WIP;
          end
        end
      end
      ST_BUSY: begin
        if (rf_edge && (rf_s[RB_CRC_BAD] || rf_s[RB_DONE])) begin
          s_nxt.st = ST_IDLE;
        end
      end
      ST_WIP: begin
        if (rf_edge && rf_s[RB_ANS]) begin
          s_nxt.st = ST_IDLE;
        end
      end
    endcase
    if (!field) begin
      s_nxt.st = ST_IDLE;
    end

    // Serial host access
    if (i_host_rd) begin
      s_nxt.ack = 1'b1;
      s_nxt.rdata = 8'h00;
      if (i_system_area_select) begin
        if (i_host_addr < SSB_BASE + SECTORS[ADDR_W-1:0]) begin
          s_nxt.rdata = s_r.ssb[i_host_addr[SEC_W-1:0]];
        end else if (i_host_addr[ADDR_W-1:3] == LOCK_LOW_ADDR[ADDR_W-1:3]) begin
          s_nxt.rdata = s_r.lock[{lock_byte, 3'h0}+:8];
        end else if (i_host_addr == CONFIG_ADDR) begin
          s_nxt.rdata = s_r.cfg;
        end else if (i_host_addr == CONTROL_ADDR) begin
          s_nxt.rdata[CTL_EH_EN] = s_r.eh_en;
          s_nxt.rdata[CTL_FIELD] = field;
          s_nxt.rdata[CTL_TPROG] = i_host_tprog;
        end else begin
          s_nxt.ack = 1'b0;
          s_nxt.err = 1'b1;
        end
      end
    end else if (i_host_wr) begin
      s_nxt.ack = 1'b1;
      if (!i_system_area_select) begin
        if (s_r.lock[host_sec]) begin
          s_nxt.ack = 1'b0;
          s_nxt.err = 1'b1;
        end
      end else if (i_host_addr < SSB_BASE + SECTORS[ADDR_W-1:0]) begin
        if (i_host_pwd_ok) begin
          s_nxt.ssb[i_host_addr[SEC_W-1:0]] = {3'h0, i_host_wdata[4:0] & SSB_WR_MASK};
        end else begin
          s_nxt.ack = 1'b0;
          s_nxt.err = 1'b1;
        end
      end else if (i_host_addr[ADDR_W-1:3] == LOCK_LOW_ADDR[ADDR_W-1:3]) begin
        if (i_host_pwd_ok) begin
          s_nxt.lock[{lock_byte, 3'h0}+:8] = i_host_wdata;
        end else begin
          s_nxt.ack = 1'b0;
          s_nxt.err = 1'b1;
        end
      end else if (i_host_addr == CONFIG_ADDR) begin
        s_nxt.cfg = i_host_wdata;
      end else if (i_host_addr == CONTROL_ADDR) begin
        s_nxt.eh_en = i_host_wdata[CTL_EH_EN];
      end else begin
        s_nxt.ack = 1'b0;
        s_nxt.err = 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      s_r <= '0;
      s_r.st <= ST_IDLE;
      s_r.lock <= LOCK_RESET;
      s_r.cfg <= CONFIG_DEFAULT;
      s_r.init <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Pin only ever sinks; any serial command keeps it floating
  assign o_rf_activity_pin_o = 1'b0;
  assign o_rf_activity_pin_oe = (s_r.st != ST_IDLE) && !i_host_busy;
  assign o_eh_out_en = s_r.eh_en && i_min_rf_input_power && i_sink_ok;
  assign o_eh_level = s_r.cfg[CFG_EH_LVL_HI-:2];
  assign o_rf_rd_ok = s_r.rd_ok;
  assign o_rf_wr_ok = s_r.wr_ok;
  assign o_host_rdata = s_r.rdata;
  assign o_host_ack = s_r.ack;
  assign o_host_err = s_r.err;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  a_wrong_pwd_clear: assert property (
    rf_edge && rf_s[RB_PWD] && !rf_s[RB_PWD_OK] |=> s_r.pwd_ok == '0)
    else $error("bad password left rights active");
  a_pwd_one_grant: assert property (
    rf_edge && rf_s[RB_PWD] && rf_s[RB_PWD_OK] && rf_s[RB_IDX+:2] == 2'h1 |=> s_r.pwd_ok[0])
    else $error("password one not granted");
  a_pin_never_high: assert property (
    o_rf_activity_pin_o == 1'b0)
    else $error("activity pin driven high");
  a_busy_sof_low: assert property (
    s_r.st == ST_IDLE && field && rf_edge && !wip_mode && rf_s[RB_SOF] |=>
    s_r.st == ST_BUSY ##0 (o_rf_activity_pin_oe || i_host_busy))
    else $error("busy not entered at start of frame");
  a_crc_release: assert property (
    s_r.st == ST_BUSY && rf_edge && rf_s[RB_CRC_BAD] |=> s_r.st == ST_IDLE && !o_rf_activity_pin_oe)
    else $error("pin held past bad command crc");
  a_field_release: assert property (
    !field |=> !o_rf_activity_pin_oe)
    else $error("pin held without field");
  a_host_float: assert property (
    i_host_busy |-> !o_rf_activity_pin_oe)
    else $error("pin driven during serial command");
  a_wip_window: assert property (
    s_r.st == ST_IDLE && field && rf_edge && wip_mode && rf_s[RB_WR_END] |=> s_r.st == ST_WIP)
    else $error("write interval not signalled");
  a_lock_blocks: assert property (
    i_host_wr && !i_host_rd && !i_system_area_select && s_r.lock[host_sec] |=> o_host_err && !o_host_ack)
    else $error("locked sector write accepted");
  a_lock_needs_pwd: assert property (
    i_host_wr && !i_host_rd && i_system_area_select && !i_host_pwd_ok |=> $stable(s_r.lock))
    else $error("lock area changed without password");
  a_eh_gate: assert property (
    o_eh_out_en |-> s_r.eh_en && i_min_rf_input_power)
    else $error("harvest output without enable");
  a_busy_done_exit: assert property (
    s_r.st == ST_BUSY && rf_edge && rf_s[RB_DONE] |=> s_r.st == ST_IDLE)
    else $error("busy held past command done");
  a_wip_answer_exit: assert property (
    s_r.st == ST_WIP && rf_edge && rf_s[RB_ANS] |=> s_r.st == ST_IDLE)
    else $error("write interval held past answer");
  a_wip_no_busy: assert property (
    s_r.st == ST_IDLE && wip_mode |=> s_r.st != ST_BUSY)
    else $error("busy entered in write mode");
  a_status_needs_pwd: assert property (
    i_host_wr && !i_host_rd && i_system_area_select && !i_host_pwd_ok |=> $stable(s_r.ssb))
    else $error("status byte changed without password");
  a_unlocked_rights: assert property (
    !sel_ssb[SSB_LOCK] |=> o_rf_rd_ok && o_rf_wr_ok)
    else $error("unlocked sector lost access");

  c_busy_cycle: cover property (s_r.st == ST_BUSY ##[1:400] s_r.st == ST_IDLE);
  c_wip_cycle: cover property (s_r.st == ST_WIP ##[1:400] s_r.st == ST_IDLE);
  c_lock_write: cover property (i_host_wr && i_system_area_select && i_host_pwd_ok);
  c_pwd_grant: cover property ($rose(s_r.pwd_ok[0]));
endmodule // ssg_sector_guard
`default_nettype wire

/* ssg_sync3.sv */
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Inputs are asynchronous to i_mclk
// Notes: Output moves only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module ssg_sync3 #(
  parameter int unsigned W = 1
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } ssg_sync_t;
  ssg_sync_t st_r;
  ssg_sync_t st_nxt;
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = i_async;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < W; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.q[i] = st_r.s3[i];
      end
    end
  end
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign o_q = st_r.q;
endmodule // ssg_sync3
`default_nettype wire
